// >>> logic/serial_ctrl_defs.svh
// Register indices, field positions, reset values and counts of the serial control block
`ifndef SERIAL_CTRL_DEFS_SVH
`define SERIAL_CTRL_DEFS_SVH

// Register indices on the plain register port
`define REG_AW 2
`define IDX_CTRL_A 2'h0
`define IDX_CTRL_B 2'h1
`define IDX_STATUS 2'h2

// Control register A fields
`define A_LOOP 7
`define A_ON 6
`define A_INV 5
`define A_NINE 4
`define A_WAKE_ADDR 3
`define A_QUIET_ORG 2
`define A_PAR_ON 1
`define A_PAR_ODD 0

// Control register B fields
`define B_TXE_IRQ 7
`define B_TXD_IRQ 6
`define B_RXF_IRQ 5
`define B_QUIET_IRQ 4
`define B_TX_EN 3
`define B_RX_EN 2
`define B_STANDBY 1
`define B_BREAK 0

// Status register fields
`define S_EMPTY 0
`define S_DONE 1
`define S_BUSY 2

// Reset values and frame sizes
`define CTRL_RESET 8'h00
`define FRAME_SHORT 4'ha
`define FRAME_LONG 4'hb
`define DIV_W 16
`define BIT_CYCLES_DEF 16'h0010

`endif

// >>> logic/serial_ctrl_pkg.sv
// Types shared by the serial control block
`include "serial_ctrl_defs.svh"

package serial_ctrl_pkg;

  // Transmit sequencer states
  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_SHIFT = 3'b010,
    TX_MARK  = 3'b100
  } tx_state_t;

  // Complete state of the control block
  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] rdata;
    tx_state_t st;
    logic [10:0] shift;
    logic [3:0] cnt;
    logic [`DIV_W-1:0] div;
    logic line;
    logic pre;
    logic brk;
    logic pre_pend;
    logic brk_pend;
    logic tx_empty;
    logic tx_done;
    logic take;
    logic rxf_set;
    logic q_set;
  } ctl_state_t;

  // State of the two-stage synchroniser
  typedef struct packed {
    logic meta;
    logic q;
  } sync_state_t;

endpackage

// >>> logic/pin_sync.sv
// Two-stage synchroniser for a pin input
`timescale 1ns/1ns

module pin_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Pin level and synchronised level
  input wire logic d_i,
  output logic q_o
);

  serial_ctrl_pkg::sync_state_t s_r;
  serial_ctrl_pkg::sync_state_t s_nxt;

  // First stage feeds only the second
  always_comb begin
    s_nxt = s_r;
    s_nxt.meta = d_i;
    s_nxt.q = s_r.meta;
  end

  // State register
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= {RESET_VAL, RESET_VAL};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q_o = s_r.q;

endmodule

// >>> logic/async_serial_control.sv
// Control part of an asynchronous serial transceiver: pins, control registers, tx framing
`timescale 1ns/1ns
`include "serial_ctrl_defs.svh"

module async_serial_control #(
  parameter logic [`DIV_W-1:0] BIT_CYCLES = `BIT_CYCLES_DEF
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Register port
  input wire logic [`REG_AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Shared port pins and their port-mode settings
  input wire logic port_e_bit0_i,
  input wire logic port_e_bit1_i,
  input wire logic port_e_dir_bit2_i,
  input wire logic port_e_dir_bit1_i,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe_o,
  input wire logic serial_in_pin_i,
  output logic serial_in_pin_o,
  output logic serial_in_pin_oe_o,
  // Transmit data path
  input wire logic [8:0] tx_data_i,
  input wire logic tx_data_valid_i,
  input wire logic tx_empty_clr_i,
  output logic tx_data_take_o,
  output logic tx_empty_flag_o,
  output logic tx_done_flag_o,
  // Receive data path
  input wire logic rx_char_done_i,
  input wire logic rx_char_msb_i,
  input wire logic rx_idle_char_i,
  input wire logic rx_full_flag_i,
  input wire logic quiet_flag_i,
  output logic rx_line_o,
  output logic rx_on_o,
  output logic rx_full_set_o,
  output logic quiet_flag_set_o,
  output logic char_nine_o,
  output logic parity_on_o,
  output logic parity_odd_sel_o,
  output logic quiet_count_origin_o,
  // Interrupt requests
  output logic tx_irq_o,
  output logic rx_irq_o
);

  serial_ctrl_pkg::ctl_state_t s_r;
  serial_ctrl_pkg::ctl_state_t s_nxt;

  logic module_on;
  logic tx_enable;
  logic rx_enable;
  logic rx_standby;
  logic tick;
  logic [3:0] frame_len;
  logic brk_src;
  logic can_start;
  logic has_work;
  logic rx_sync;
  logic tx_level;
  logic wake_hit;
  logic [7:0] ctrl_b_wr;

  // Frame image, start bit in bit 0, ones above the stop bit
  function automatic logic [10:0] build_frame(input logic [8:0] d, input logic nine,
                                              input logic par_on, input logic odd);
    logic [10:0] f;
    f = {11{1'b1}};
    if (nine) begin
      f[9:1] = d;
    end else begin
      f[8:1] = d[7:0];
    end
    if (par_on && nine) begin
      f[9] = (^d[7:0]) ^ odd;
    end else if (par_on) begin
      f[8] = (^d[6:0]) ^ odd;
    end
    f[0] = 1'b0;
    return f;
  endfunction

  // Receive pin synchroniser
  pin_sync #(
    .RESET_VAL(1'b1)
  ) u_rx_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .d_i(serial_in_pin_i),
    .q_o(rx_sync)
  );

  // Control field decode
  assign module_on = s_r.ctrl_a[`A_ON];
  assign tx_enable = s_r.ctrl_b[`B_TX_EN];
  assign rx_enable = s_r.ctrl_b[`B_RX_EN];
  assign rx_standby = s_r.ctrl_b[`B_STANDBY];

  // Bit clock and frame scheduling terms
  assign tick = module_on && (s_r.div == '0);
  assign frame_len = s_r.ctrl_a[`A_NINE] ? `FRAME_LONG : `FRAME_SHORT;
  assign brk_src = s_r.brk_pend | s_r.ctrl_b[`B_BREAK];
  assign can_start = (s_r.st == serial_ctrl_pkg::TX_IDLE) ||
                     (s_r.st == serial_ctrl_pkg::TX_MARK) ||
                     ((s_r.st == serial_ctrl_pkg::TX_SHIFT) && (s_r.cnt == 4'h0) &&
                      (!s_r.brk || brk_src));
  assign has_work = tx_enable && (brk_src || s_r.pre_pend || tx_data_valid_i);
  assign tx_level = s_r.line ^ s_r.ctrl_a[`A_INV];

  // Wake condition seen while in standby
  assign wake_hit = rx_on_o && rx_standby &&
                    (s_r.ctrl_a[`A_WAKE_ADDR] ? (rx_char_done_i && rx_char_msb_i)
                                              : rx_idle_char_i);

  // Control B write image; enables hold while the module is off
  always_comb begin
    ctrl_b_wr = wdata_i;
    if (!module_on) begin
      ctrl_b_wr[`B_TX_EN] = s_r.ctrl_b[`B_TX_EN];
      ctrl_b_wr[`B_RX_EN] = s_r.ctrl_b[`B_RX_EN];
    end
  end

  // Next-state logic
  always_comb begin
    s_nxt = s_r;
    s_nxt.take = 1'b0;
    s_nxt.rxf_set = 1'b0;
    s_nxt.q_set = 1'b0;
    s_nxt.rdata = 8'h00;

    // Bit divider runs only while the module is on
    if (!module_on) begin
      s_nxt.div = '0;
    end else if (tick) begin
      s_nxt.div = BIT_CYCLES - 16'h0001;
    end else begin
      s_nxt.div = s_r.div - 16'h0001;
    end

    // Transmit sequencer, one step per bit time
    if (tick) begin
      if (can_start && has_work) begin
        s_nxt.st = serial_ctrl_pkg::TX_SHIFT;
        s_nxt.cnt = frame_len - 4'h1;
        if (brk_src) begin
          s_nxt.brk = 1'b1;
          s_nxt.pre = 1'b0;
          s_nxt.brk_pend = 1'b0;
          s_nxt.pre_pend = 1'b0;
          s_nxt.shift = '0;
          s_nxt.line = 1'b0;
        end else if (s_r.pre_pend) begin
          s_nxt.pre = 1'b1;
          s_nxt.brk = 1'b0;
          s_nxt.pre_pend = 1'b0;
          s_nxt.shift = '1;
          s_nxt.line = 1'b1;
        end else begin
          s_nxt.pre = 1'b0;
          s_nxt.brk = 1'b0;
          s_nxt.shift = build_frame(tx_data_i, s_r.ctrl_a[`A_NINE],
                                    s_r.ctrl_a[`A_PAR_ON], s_r.ctrl_a[`A_PAR_ODD]);
          s_nxt.line = 1'b0;
          s_nxt.take = 1'b1;
        end
      end else if ((s_r.st == serial_ctrl_pkg::TX_SHIFT) && (s_r.cnt != 4'h0)) begin
        // Frame runs on even after tx enable drops
        s_nxt.line = s_r.shift[1];
        s_nxt.shift = {s_r.shift[10], s_r.shift[10:1]};
        s_nxt.cnt = s_r.cnt - 4'h1;
      end else if ((s_r.st == serial_ctrl_pkg::TX_SHIFT) && s_r.brk) begin
        // One mark bit after the last break
        s_nxt.st = serial_ctrl_pkg::TX_MARK;
        s_nxt.line = 1'b1;
        s_nxt.brk = 1'b0;
      end else begin
        s_nxt.st = serial_ctrl_pkg::TX_IDLE;
        s_nxt.line = 1'b1;
        s_nxt.pre = 1'b0;
        s_nxt.brk = 1'b0;
      end
    end

    // Module off parks the sequencer on the idle level
    if (!module_on) begin
      s_nxt.st = serial_ctrl_pkg::TX_IDLE;
      s_nxt.line = 1'b1;
      s_nxt.pre = 1'b0;
      s_nxt.brk = 1'b0;
      s_nxt.pre_pend = 1'b0;
      s_nxt.brk_pend = 1'b0;
    end

    // Empty flag: hand-off or disable sets, data-path write clears, set wins
    if (tx_empty_clr_i) begin
      s_nxt.tx_empty = 1'b0;
    end
    if (s_nxt.take || !module_on) begin
      s_nxt.tx_empty = 1'b1;
    end
    s_nxt.tx_done = !module_on ||
                    (s_nxt.tx_empty && (s_nxt.st == serial_ctrl_pkg::TX_IDLE) && !has_work);

    // Receive flag set requests and wake handling
    s_nxt.rxf_set = rx_on_o && rx_char_done_i &&
                    (!rx_standby || (s_r.ctrl_a[`A_WAKE_ADDR] && rx_char_msb_i));
    s_nxt.q_set = rx_on_o && rx_idle_char_i && !rx_standby;
    if (wake_hit) begin
      s_nxt.ctrl_b[`B_STANDBY] = 1'b0;
    end

    // Register writes; software write to standby overrides a wake
    if (wr_i) begin
      case (addr_i)
        `IDX_CTRL_A: begin
          s_nxt.ctrl_a = wdata_i;
        end
        `IDX_CTRL_B: begin
          s_nxt.ctrl_b = ctrl_b_wr;
          if (ctrl_b_wr[`B_TX_EN] && !tx_enable && module_on) begin
            s_nxt.pre_pend = 1'b1;
          end
          if (ctrl_b_wr[`B_BREAK] && !s_r.ctrl_b[`B_BREAK] && module_on) begin
            s_nxt.brk_pend = 1'b1;
          end
        end
        default: begin
          s_nxt.rdata = 8'h00;
        end
      endcase
    end

    // Register reads, data valid in the next cycle only
    if (rd_i) begin
      case (addr_i)
        `IDX_CTRL_A: s_nxt.rdata = s_r.ctrl_a;
        `IDX_CTRL_B: s_nxt.rdata = s_r.ctrl_b;
        `IDX_STATUS: begin
          s_nxt.rdata[`S_EMPTY] = s_r.tx_empty;
          s_nxt.rdata[`S_DONE] = s_r.tx_done;
          s_nxt.rdata[`S_BUSY] = (s_r.st != serial_ctrl_pkg::TX_IDLE);
        end
        default: s_nxt.rdata = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.ctrl_a <= `CTRL_RESET;
      s_r.ctrl_b <= `CTRL_RESET;
      s_r.st <= serial_ctrl_pkg::TX_IDLE;
      s_r.line <= 1'b1;
      s_r.tx_empty <= 1'b1;
      s_r.tx_done <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Pin takeover and port-mode fallback
  assign serial_out_pin_o = module_on ? tx_level : port_e_bit0_i;
  assign serial_out_pin_oe_o = module_on ? 1'b1 : port_e_dir_bit2_i;
  assign serial_in_pin_o = port_e_bit1_i;
  assign serial_in_pin_oe_o = module_on ? 1'b0 : port_e_dir_bit1_i;

  // Receiver input selection
  assign rx_line_o = s_r.ctrl_a[`A_LOOP] ? tx_level : rx_sync;
  assign rx_on_o = module_on && rx_enable;

  // Settings passed to the data path
  assign char_nine_o = s_r.ctrl_a[`A_NINE];
  assign parity_on_o = s_r.ctrl_a[`A_PAR_ON];
  assign parity_odd_sel_o = s_r.ctrl_a[`A_PAR_ODD];
  assign quiet_count_origin_o = s_r.ctrl_a[`A_QUIET_ORG];

  // Registered outputs
  assign rdata_o = s_r.rdata;
  assign tx_data_take_o = s_r.take;
  assign tx_empty_flag_o = s_r.tx_empty;
  assign tx_done_flag_o = s_r.tx_done;
  assign rx_full_set_o = s_r.rxf_set;
  assign quiet_flag_set_o = s_r.q_set;

  // Interrupt requests
  assign tx_irq_o = module_on &&
                    ((s_r.tx_empty && s_r.ctrl_b[`B_TXE_IRQ]) ||
                     (s_r.tx_done && s_r.ctrl_b[`B_TXD_IRQ]));
  assign rx_irq_o = !rx_standby &&
                    ((rx_full_flag_i && s_r.ctrl_b[`B_RXF_IRQ]) ||
                     (quiet_flag_i && s_r.ctrl_b[`B_QUIET_IRQ]));

  // Checks on the block's own behaviour
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  a_off_sets_flags: assert property (
    !module_on |-> (!tx_irq_o ##1 (tx_empty_flag_o && tx_done_flag_o)))
    else $error("disable did not set empty and done");
  a_pin_takeover: assert property (
    module_on |-> (serial_out_pin_oe_o && !serial_in_pin_oe_o))
    else $error("pins not taken over while enabled");
  a_idle_polarity: assert property (
    (module_on && s_r.st == serial_ctrl_pkg::TX_IDLE) |->
    (serial_out_pin_o == !s_r.ctrl_a[`A_INV]))
    else $error("idle level wrong for inversion");
  a_take_empty: assert property (
    tx_data_take_o |-> (tx_empty_flag_o && s_r.line == 1'b0 &&
    s_r.cnt == frame_len - 4'h1))
    else $error("hand-off did not start a full frame");
  a_preamble_ones: assert property (
    (s_r.st == serial_ctrl_pkg::TX_SHIFT && s_r.pre) |-> s_r.line)
    else $error("preamble bit not one");
  a_break_zeros: assert property (
    (s_r.st == serial_ctrl_pkg::TX_SHIFT && s_r.brk) |-> !s_r.line)
    else $error("break bit not zero");
  a_break_tail: assert property (
    (tick && s_r.st == serial_ctrl_pkg::TX_SHIFT && s_r.brk && s_r.cnt == 4'h0 &&
     !brk_src) |=> (s_r.st == serial_ctrl_pkg::TX_MARK && s_r.line))
    else $error("no mark bit after break");
  a_frame_finish: assert property (
    ($fell(tx_enable) && module_on && s_r.st == serial_ctrl_pkg::TX_SHIFT &&
     s_r.cnt != 4'h0) |=> (s_r.st == serial_ctrl_pkg::TX_SHIFT))
    else $error("frame aborted by tx enable clear");
  a_idle_wake: assert property (
    (wake_hit && !s_r.ctrl_a[`A_WAKE_ADDR] && !wr_i) |=>
    (!rx_standby && !quiet_flag_set_o && !rx_full_set_o))
    else $error("idle wake set a flag or kept standby");
  a_standby_mute: assert property (
    rx_standby |-> !rx_irq_o)
    else $error("rx irq while in standby");

endmodule

// >>> verification/serial_node_model.sv
// Far-side serial node: pulled-up return line and a frame sampler on the transmit wire
`timescale 1ns/1ns

module serial_node_model #(
  parameter int BIT_CYCLES = 4
) (
  // Clock
  input wire logic clk_sys_i,
  // Transmit wire from the block and the line returned to it
  input wire logic line_i,
  output logic line_o,
  // Settings and commands from the bench
  input wire logic inv_i,
  input wire logic [3:0] frame_bits_i,
  input wire logic hold_low_i,
  // Last captured frame, start bit in bit 0, and count of frames seen
  output logic [10:0] frame_o = 11'h000,
  output logic [7:0] frame_cnt_o = 8'h00
);
  logic prev = 1'b1;
  logic busy = 1'b0;
  logic [3:0] idx = 4'h0;
  int wait_cnt = 0;
  logic lvl;

  // Pull-up keeps the returned line high unless the bench holds it low on purpose
  assign line_o = hold_low_i ? 1'b0 : 1'b1;
  assign lvl = line_i ^ inv_i;

  // Falling edge starts a frame; every cell is sampled near its middle, first bit first
  always @(posedge clk_sys_i) begin
    prev <= lvl;
    if (!busy) begin
      if (prev === 1'b1 && lvl === 1'b0) begin
        busy <= 1'b1;
        idx <= 4'h0;
        frame_o <= 11'h000;
        wait_cnt <= BIT_CYCLES / 2 - 1;
      end
    end else if (wait_cnt != 0) begin
      wait_cnt <= wait_cnt - 1;
    end else begin
      frame_o[idx] <= lvl;
      idx <= idx + 4'h1;
      wait_cnt <= BIT_CYCLES - 1;
      if (idx == frame_bits_i - 4'h1) begin
        busy <= 1'b0;
        frame_cnt_o <= frame_cnt_o + 8'h01;
      end
    end
  end
endmodule

// >>> verification/async_serial_control_tb.sv
// Self-checking bench for the serial control block
`timescale 1ns/1ns
`include "serial_ctrl_defs.svh"

module async_serial_control_tb;
  localparam int B = 4;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0, rd_s = 1'b0, txv = 1'b0, eclr = 1'b0, cdone = 1'b0, cmsb = 1'b0;
  logic idle_c = 1'b0, rxff = 1'b0, qf = 1'b0, inv = 1'b0, hold = 1'b0, seen_low;
  logic [8:0] txd = 9'h000;
  logic [3:0] fbits = 4'ha;
  logic [7:0] rdata, v, c;
  logic [10:0] frame;
  logic [7:0] fcnt;
  logic pin_out, pin_oe, in_pin_o, in_oe, node_line, tx_wire, in_wire, take, empty, done;
  logic rx_line, rx_on, rxf_set, q_set, nine, par_on, par_odd, q_org, tx_irq, rx_irq;
  logic [2:0] fmt [6] = '{3'b000, 3'b100, 3'b010, 3'b011, 3'b110, 3'b111};
  int fails = 0;
  int samples_checked = 0;
  int n, i;

  // Wire levels from every party's enable, pulled up when nobody drives
  assign tx_wire = pin_oe ? pin_out : 1'b1;
  assign in_wire = in_oe ? in_pin_o : node_line;

  // Clock
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  async_serial_control #(.BIT_CYCLES(16'(B))) uut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s),
    .rd_i(rd_s), .rdata_o(rdata), .port_e_bit0_i(1'b1), .port_e_bit1_i(1'b1),
    .port_e_dir_bit2_i(1'b0), .port_e_dir_bit1_i(1'b1), .serial_out_pin_o(pin_out),
    .serial_out_pin_oe_o(pin_oe), .serial_in_pin_i(in_wire), .serial_in_pin_o(in_pin_o),
    .serial_in_pin_oe_o(in_oe), .tx_data_i(txd), .tx_data_valid_i(txv),
    .tx_empty_clr_i(eclr), .tx_data_take_o(take), .tx_empty_flag_o(empty),
    .tx_done_flag_o(done), .rx_char_done_i(cdone), .rx_char_msb_i(cmsb),
    .rx_idle_char_i(idle_c), .rx_full_flag_i(rxff), .quiet_flag_i(qf), .rx_line_o(rx_line),
    .rx_on_o(rx_on), .rx_full_set_o(rxf_set), .quiet_flag_set_o(q_set), .char_nine_o(nine),
    .parity_on_o(par_on), .parity_odd_sel_o(par_odd), .quiet_count_origin_o(q_org),
    .tx_irq_o(tx_irq), .rx_irq_o(rx_irq));

  serial_node_model #(.BIT_CYCLES(B)) node (
    .clk_sys_i(clk_sys_i), .line_i(tx_wire), .line_o(node_line), .inv_i(inv),
    .frame_bits_i(fbits), .hold_low_i(hold), .frame_o(frame), .frame_cnt_o(fcnt));

  // Comparison and verdict
  task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic lost(input string msg);
    fails++;
    $display("wrong value at %0t ns: no %s in time", $time, msg);
    end_sim();
  endtask

  // Register port cycles
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_sys_i);
    wr_s <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_sys_i);
    rd_s <= 1'b0;
    #1;
    chk({3'h0, rdata}, {3'h0, exp}, "register read");
  endtask

  // Expected frame: start, data first bit first, parity or top bit, stop
  function automatic logic [10:0] fr(input logic [8:0] d, input logic [2:0] f);
    logic p;
    p = (f[2] ? ^d[7:0] : ^d[6:0]) ^ f[0];
    if (f[2]) begin
      fr = {1'b1, f[1] ? p : d[8], d[7:0], 1'b0};
    end else begin
      fr = {2'b01, f[1] ? p : d[7], d[6:0], 1'b0};
    end
  endfunction

  // Hand one character over as the data register and wait for its frame
  task automatic send(input logic [8:0] d, input logic [10:0] exp, input logic drop_en);
    logic [7:0] c0;
    int k;
    c0 = fcnt;
    k = 0;
    n = 0;
    seen_low = 1'b0;
    @(posedge clk_sys_i);
    txd <= d;
    txv <= 1'b1;
    eclr <= 1'b1;
    @(posedge clk_sys_i);
    eclr <= 1'b0;
    #1;
    while (take !== 1'b1) begin
      if (pin_out !== ~inv) seen_low = 1'b1;
      @(posedge clk_sys_i);
      #1;
      n++;
      if (n > 2000) lost("take");
    end
    chk(empty, 1'b1, "empty flag after take");
    @(posedge clk_sys_i);
    txv <= 1'b0;
    if (drop_en) wr(2'h1, 8'h00);
    while (fcnt === c0) begin
      @(posedge clk_sys_i);
      #1;
      k++;
      if (k > 2000) lost("frame");
    end
    chk(frame, exp, "frame on the line");
  endtask

  task automatic wait_pin(input logic lvl);
    int k;
    k = 0;
    while (pin_out !== lvl) begin
      @(posedge clk_sys_i);
      #1;
      k++;
      if (k > 40 * B) lost("pin level");
    end
  endtask

  // Receiver event pulse and the flag requests one cycle later
  task automatic rx_evt(input logic idle_ev, input logic msb, input logic [1:0] exp);
    @(posedge clk_sys_i);
    idle_c <= idle_ev;
    cdone <= ~idle_ev;
    cmsb <= msb;
    @(posedge clk_sys_i);
    idle_c <= 1'b0;
    cdone <= 1'b0;
    #1;
    chk({rxf_set, q_set}, exp, "receiver flag request");
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'h03);
    rd(2'h3, 8'h00);
    chk({tx_irq, rx_irq, pin_oe, in_oe, in_pin_o, pin_out}, 6'b000111, "pins while off");
    wr(2'h1, 8'h0c);
    rd(2'h1, 8'h00);
    wr(2'h0, 8'h40);
    chk({pin_oe, pin_out, in_oe}, 3'b110, "pins while on");
    for (i = 0; i < 5; i++) begin
      v = 8'h40 | (8'h01 << i);
      wr(2'h0, v);
      chk({nine, q_org, par_on, par_odd}, {v[4], v[2], v[1], v[0]}, "format outs");
      rd(2'h0, v);
    end
    wr(2'h0, 8'h40);
    wr(2'h1, 8'h08);
    send(9'h0a5, fr(9'h0a5, 3'b000), 1'b0);
    chk(n >= 10 * B - 4 && n <= 11 * B + 2, 1'b1, "preamble length");
    chk(seen_low, 1'b0, "line high in preamble");
    for (i = 0; i < 6; i++) begin
      fbits = fmt[i][2] ? 4'hb : 4'ha;
      wr(2'h0, {3'b010, fmt[i][2], 2'b00, fmt[i][1:0]});
      send(9'h1b3, fr(9'h1b3, fmt[i]), 1'b0);
    end
    fbits = 4'ha;
    inv = 1'b1;
    wr(2'h0, 8'h60);
    repeat (12 * B) @(posedge clk_sys_i);
    #1;
    chk(pin_out, 1'b0, "inverted idle level");
    send(9'h03c, fr(9'h03c, 3'b000), 1'b0);
    inv = 1'b0;
    wr(2'h0, 8'h40);
    repeat (12 * B) @(posedge clk_sys_i);
    send(9'h0f1, fr(9'h0f1, 3'b000), 1'b1);
    repeat (B) @(posedge clk_sys_i);
    #1;
    chk(pin_out, 1'b1, "idle after transmitter off");
    rd(2'h2, 8'h03);
    wr(2'h1, 8'h08);
    wr(2'h1, 8'h09);
    wait_pin(1'b0);
    n = 0;
    repeat (20 * B) begin
      @(posedge clk_sys_i);
      #1;
      if (pin_out === 1'b0) n++;
    end
    chk(n, 20 * B, "breaks back to back");
    chk(frame, 11'h000, "break frame");
    wr(2'h1, 8'h08);
    wait_pin(1'b1);
    repeat (B - 1) @(posedge clk_sys_i);
    #1;
    chk(pin_out, 1'b1, "mark after break");
    repeat (2 * B) @(posedge clk_sys_i);
    wr(2'h1, 8'h80);
    chk(tx_irq, 1'b1, "empty irq");
    wr(2'h1, 8'h40);
    chk(tx_irq, 1'b1, "done irq");
    wr(2'h1, 8'hc0);
    @(posedge clk_sys_i);
    eclr <= 1'b1;
    @(posedge clk_sys_i);
    eclr <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk({empty, done, tx_irq}, 3'b000, "irq follows flags");
    wr(2'h0, 8'h00);
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk({empty, done, tx_irq}, 3'b110, "module off");
    wr(2'h0, 8'h48);
    wr(2'h1, 8'h24);
    @(posedge clk_sys_i);
    rxff <= 1'b1;
    @(posedge clk_sys_i);
    #1;
    chk({rx_on, rx_irq}, 2'b11, "full irq");
    wr(2'h1, 8'h26);
    chk(rx_irq, 1'b0, "standby mutes irq");
    rx_evt(1'b0, 1'b0, 2'b00);
    rd(2'h1, 8'h26);
    rx_evt(1'b0, 1'b1, 2'b10);
    rd(2'h1, 8'h24);
    @(posedge clk_sys_i);
    rxff <= 1'b0;
    qf <= 1'b1;
    wr(2'h1, 8'h24);
    chk(rx_irq, 1'b0, "quiet flag without enable");
    wr(2'h1, 8'h14);
    chk(rx_irq, 1'b1, "quiet irq");
    wr(2'h0, 8'h40);
    wr(2'h1, 8'h06);
    rx_evt(1'b1, 1'b0, 2'b00);
    rd(2'h1, 8'h04);
    rx_evt(1'b1, 1'b0, 2'b01);
    hold = 1'b1;
    wr(2'h0, 8'hc0);
    wr(2'h1, 8'h0c);
    chk(rx_line, 1'b1, "loopback ignores pin");
    wr(2'h0, 8'h40);
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk(rx_line, 1'b0, "receive pin reaches receiver");
    end_sim();
  end
endmodule
